// File: design/sensor_regs.vh
`ifndef SENSOR_REGS_VH
`define SENSOR_REGS_VH
// register byte addresses
`define ADDR_PART_ID0 8'h00
`define ADDR_DIE_REV0 8'h02
`define ADDR_UID0 8'h04
`define ADDR_UID_LAST 8'h0B
`define ADDR_SYS_CONTROL 8'h10
`define ADDR_SYS_STATE 8'h11
`define ADDR_RUN_MODE 8'h21
`define ADDR_TRIGGER 8'h22
`define ADDR_HALT 8'h23
`define ADDR_ACTIVITY 8'h24
`define ADDR_TEMP0 8'h30
`define ADDR_TEMP2 8'h32
`define ADDR_HUMID0 8'h33
`define ADDR_HUMID2 8'h35
// field positions
`define BIT_SELF_RESET 7
`define BIT_LOW_POWER 0
`define BIT_AWAKE 0
`define BIT_HUMID 1
`define BIT_TEMP 0
`define BIT_VALID 16
// reset values
`define RST_LOW_POWER 1'b1
`define RST_AWAKE 1'b1
`define RST_RUN_MODE 2'h0
// identity values, arbitrary
`define ID_PART 16'h5AA5
`define ID_DIE 16'h0007
`define ID_UNIQUE 64'h0123_4567_89AB_CDEF
// timing: self reset pulse length in cycles
`define SELF_RESET_CYCLES 4'h4
`endif

// File: design/reset_sync.v
`timescale 1ns/1ps
`default_nettype none
module reset_sync (
    input wire clock_i,
    input wire rst_b_i,
    input wire soft_i,
    output wire rst_b_o
);
    reg [1:0] sync;
    // two-stage release of external reset
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i)
            sync <= 2'h0;
        else
            sync <= {sync[0], 1'b1};
    end
    assign rst_b_o = sync[1] & ~soft_i;
endmodule
`default_nettype wire

// File: design/readout_latch.v
`timescale 1ns/1ps
`default_nettype none
module readout_latch (
    input wire clock_i,
    input wire rst_b_i,
    input wire capture_i,
    input wire [23:0] live_i,
    input wire [1:0] sel_i,
    output wire [7:0] byte_o
);
    reg [23:0] shadow;
    // host-visible copy, loaded on lowest byte read
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i)
            shadow <= 24'h0000_0000;
        else if (capture_i)
            shadow <= live_i;
    end
    assign byte_o = capture_i ? live_i[7:0] :
                    (sel_i == 2'h1) ? shadow[15:8] :
                    (sel_i == 2'h2) ? shadow[23:16] : shadow[7:0];
endmodule
`default_nettype wire

// File: design/humidity_temp_register_map.v
// Notes on behaviour
// - multi-byte registers span consecutive byte addresses
// - identification registers readable only when active
// - part identifier little-endian, low byte first
// - read-only 64-bit unique device number
// - control bit 7 write-one resets device
// - low-power bit resets one, standby after measurement only when run mode is zero for both sensors
// - awake flag one when active, resets one
// - run mode per sensor, reset zero
// - activity register reports per-sensor measuring
// - trigger write-one starts, zero ignored
// - halt write-one stops continuous, zero ignored
// - readout holds data, valid flag, CRC
// - lowest byte read copies whole readout
`timescale 1ns/1ps
`default_nettype none
`include "sensor_regs.vh"
module humidity_temp_register_map (
    input wire clock_i,
    input wire rst_b_i,
    input wire [7:0] addr_i,
    input wire wr_i,
    input wire [7:0] wdata_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    input wire [1:0] done_i,
    input wire [1:0] busy_i,
    input wire [23:0] temp_i,
    input wire [23:0] humid_i,
    input wire booted_i,
    output wire [1:0] start_o,
    output wire [1:0] halt_o,
    output wire [1:0] run_mode_o
);
    ////////////////////////////////////////////////////////////////////////
    wire rst_b;
    reg [3:0] soft_count;
    reg low_power;
    wire awake_flag;
    // one-hot power states
    localparam [2:0] ST_BOOT = 3'b001;
    localparam [2:0] ST_STANDBY = 3'b010;
    localparam [2:0] ST_ACTIVE = 3'b100;
    reg [2:0] power_state;
    reg [2:0] next_power_state;
    wire sleep_ok;
    wire wake_req;
    // identity words, cut to bytes by part-select
    wire [15:0] id_part_word = `ID_PART;
    wire [15:0] id_die_word = `ID_DIE;
    wire [63:0] id_unique_word = `ID_UNIQUE;
    wire [2:0] uid_index = addr_i[2:0] - 3'h4;
    reg [1:0] run_mode;
    reg [1:0] trigger;
    reg [1:0] halt;
    reg [7:0] next_rdata;
    wire [7:0] temp_byte;
    wire [7:0] humid_byte;
    wire cap_temp;
    wire cap_humid;
    wire wr_ctrl;

    reset_sync u_rst (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .soft_i(soft_count != 4'h0),
        .rst_b_o(rst_b)
    );

    function in_range;
        input [7:0] a;
        input [7:0] lo;
        input [7:0] hi;
        begin
            in_range = (a >= lo) && (a <= hi);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // self reset stretcher, kept on external reset only
    assign wr_ctrl = wr_i && (addr_i == `ADDR_SYS_CONTROL);
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i)
            soft_count <= 4'h0;
        else if (wr_ctrl && wdata_i[`BIT_SELF_RESET])
            soft_count <= `SELF_RESET_CYCLES;
        else if (soft_count != 4'h0)
            soft_count <= soft_count - 4'h1;
    end

    // control, mode and command registers
    always @(posedge clock_i or negedge rst_b) begin
        if (!rst_b) begin
            low_power <= `RST_LOW_POWER;
            run_mode <= `RST_RUN_MODE;
            trigger <= 2'h0;
            halt <= 2'h0;
        end else begin
            if (wr_ctrl)
                low_power <= wdata_i[`BIT_LOW_POWER];
            if (wr_i && addr_i == `ADDR_RUN_MODE)
                run_mode <= wdata_i[1:0];
            // one-cycle command pulses, zeros ignored
            trigger <= (wr_i && addr_i == `ADDR_TRIGGER) ? wdata_i[1:0] : 2'h0;
            halt <= (wr_i && addr_i == `ADDR_HALT) ? wdata_i[1:0] : 2'h0;
        end
    end
    assign start_o = trigger;
    assign halt_o = halt;
    assign run_mode_o = run_mode;

    // power state: wake on start, sleep after completion in low power with run mode zero
    assign wake_req = (trigger != 2'h0) || !low_power;
    assign sleep_ok = (done_i != 2'h0) && (busy_i == 2'h0) && (run_mode == 2'h0);

    // next power state; booting overrides everything
    always @* begin
        next_power_state = power_state;
        case (power_state)
            ST_BOOT: begin
                if (booted_i)
                    next_power_state = wake_req ? ST_ACTIVE : ST_STANDBY;
            end
            ST_STANDBY: begin
                if (wake_req)
                    next_power_state = ST_ACTIVE;
            end
            ST_ACTIVE: begin
                if (!wake_req && sleep_ok)
                    next_power_state = ST_STANDBY;
            end
            default: begin
                next_power_state = ST_ACTIVE;
            end
        endcase
        if (!booted_i)
            next_power_state = ST_BOOT;
    end

    // power state register, comes up active
    always @(posedge clock_i or negedge rst_b) begin
        if (!rst_b)
            power_state <= ST_ACTIVE;
        else
            power_state <= next_power_state;
    end
    assign awake_flag = (power_state == ST_ACTIVE);

    ////////////////////////////////////////////////////////////////////////
    // readout double buffers
    assign cap_temp = rd_i && addr_i == `ADDR_TEMP0;
    assign cap_humid = rd_i && addr_i == `ADDR_HUMID0;
    readout_latch u_temp (
        .clock_i(clock_i),
        .rst_b_i(rst_b),
        .capture_i(cap_temp),
        .live_i(temp_i),
        .sel_i(addr_i[1:0] - 2'h0),
        .byte_o(temp_byte)
    );
    readout_latch u_humid (
        .clock_i(clock_i),
        .rst_b_i(rst_b),
        .capture_i(cap_humid),
        .live_i(humid_i),
        .sel_i(addr_i[1:0] - 2'h3),
        .byte_o(humid_byte)
    );

    // read multiplexer
    always @* begin
        next_rdata = 8'h00;
        if (in_range(addr_i, `ADDR_PART_ID0, `ADDR_UID_LAST) && awake_flag) begin
            if (addr_i == `ADDR_PART_ID0)
                next_rdata = id_part_word[7:0];
            else if (addr_i == 8'h01)
                next_rdata = id_part_word[15:8];
            else if (addr_i == `ADDR_DIE_REV0)
                next_rdata = id_die_word[7:0];
            else if (addr_i == 8'h03)
                next_rdata = id_die_word[15:8];
            else
                next_rdata = id_unique_word[{uid_index, 3'h0} +: 8];
        end else if (addr_i == `ADDR_SYS_CONTROL)
            next_rdata = {7'h00, low_power};
        else if (addr_i == `ADDR_SYS_STATE)
            next_rdata = {7'h00, awake_flag};
        else if (addr_i == `ADDR_RUN_MODE)
            next_rdata = {6'h00, run_mode};
        else if (addr_i == `ADDR_ACTIVITY)
            next_rdata = {6'h00, busy_i};
        else if (in_range(addr_i, `ADDR_TEMP0, `ADDR_TEMP2))
            next_rdata = temp_byte;
        else if (in_range(addr_i, `ADDR_HUMID0, `ADDR_HUMID2))
            next_rdata = humid_byte;
    end

    // registered read data
    always @(posedge clock_i or negedge rst_b) begin
        if (!rst_b)
            rdata_o <= 8'h00;
        else if (rd_i)
            rdata_o <= next_rdata;
    end
endmodule
`default_nettype wire

// File: sim/hum_props.sv
`timescale 1ns/1ps
`default_nettype none
module hum_props (input wire logic clock_i, input wire logic rst_b_i,
    input wire logic [7:0] addr_i, input wire logic wr_i, input wire logic [7:0] wdata_i,
    input wire logic rd_i, input wire logic [7:0] rdata_o, input wire logic [1:0] done_i,
    input wire logic [1:0] busy_i, input wire logic [23:0] temp_i,
    input wire logic booted_i, input wire logic [1:0] start_o,
    input wire logic [1:0] halt_o, input wire logic [1:0] run_mode_o);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    property p_go; wr_i && addr_i == 8'h22 |=> start_o == $past(wdata_i[1:0]); endproperty
    a_go: assert property (p_go) else $error("start");
    property p_hl; wr_i && addr_i == 8'h23 |=> halt_o == $past(wdata_i[1:0]); endproperty
    a_hl: assert property (p_hl) else $error("halt");
    property p_md; wr_i && addr_i == 8'h21 |=> run_mode_o == $past(wdata_i[1:0]); endproperty
    a_md: assert property (p_md) else $error("mode");
    property p_ac; rd_i && addr_i == 8'h24 |=> rdata_o == {6'h00, $past(busy_i)}; endproperty
    a_ac: assert property (p_ac) else $error("activity");
    property p_gp; rd_i && addr_i > 8'h35 |=> rdata_o == 8'h00; endproperty
    a_gp: assert property (p_gp) else $error("gap");
    property p_sn; rd_i && addr_i == 8'h30 |=> rdata_o == $past(temp_i[7:0]); endproperty
    a_sn: assert property (p_sn) else $error("snapshot");
    property p_st; rd_i && addr_i == 8'h11 && !booted_i && !$past(booted_i) |=> rdata_o == 8'h00;
    endproperty
    a_st: assert property (p_st) else $error("state");
    property p_id; rd_i && addr_i < 8'h0C && !booted_i && !$past(booted_i) |=> rdata_o == 8'h00;
    endproperty
    a_id: assert property (p_id) else $error("ident");
    c_go: cover property (start_o != 2'h0);
    c_dn: cover property (done_i != 2'h0);
    c_sn: cover property (rd_i && addr_i == 8'h30);
endmodule
bind humidity_temp_register_map hum_props i_props (.*);
`default_nettype wire

// File: sim/engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module engine_model (input wire logic clock_i, input wire logic [1:0] start_i,
    input wire logic [1:0] halt_i, input wire logic [1:0] mode_i,
    output logic [1:0] busy_o, output logic [1:0] done_o);
    logic [3:0] cnt [2];
    logic [1:0] stop;
    initial begin
        busy_o = 2'h0;
        done_o = 2'h0;
    end
    // per sensor conversion; continuous runs restart until a halt was seen
    always @(posedge clock_i) begin
        for (int k = 0; k < 2; k++) begin
            done_o[k] <= 1'b0;
            if (start_i[k]) begin
                busy_o[k] <= 1'b1;
                cnt[k] <= 4'h8;
                stop[k] <= 1'b0;
            end else if (halt_i[k]) begin
                stop[k] <= 1'b1;
            end else if (busy_o[k] && cnt[k] == 4'h0) begin
                done_o[k] <= 1'b1;
                busy_o[k] <= mode_i[k] & ~stop[k];
                cnt[k] <= 4'h8;
            end else if (busy_o[k]) begin
                cnt[k] <= cnt[k] - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sensor_regs.vh"
module testbench;
    logic clock_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, booted_i = 1'b1;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, d;
    logic [23:0] temp_i = 24'h00_0000, humid_i = 24'h00_0000;
    wire [7:0] rdata_o;
    wire [1:0] done_i, busy_i, start_o, halt_o, run_mode_o;
    int n_errors = 0, compares = 0, cycles = 0;
    always #5 clock_i = ~clock_i;
    humidity_temp_register_map i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
        .wr_i(wr_i), .wdata_i(wdata_i), .rd_i(rd_i), .rdata_o(rdata_o), .done_i(done_i),
        .busy_i(busy_i), .temp_i(temp_i), .humid_i(humid_i), .booted_i(booted_i),
        .start_o(start_o), .halt_o(halt_o), .run_mode_o(run_mode_o));
    engine_model i_engine (.clock_i(clock_i), .start_i(start_o), .halt_i(halt_o),
        .mode_i(run_mode_o), .busy_o(busy_i), .done_o(done_i));
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock_i); addr_i <= a; wdata_i <= v; wr_i <= 1'b1;
        @(posedge clock_i); wr_i <= 1'b0; #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock_i); addr_i <= a; rd_i <= 1'b1;
        @(posedge clock_i); rd_i <= 1'b0; #1 d = rdata_o;
    endtask
    task automatic idle;
        repeat (2) @(posedge clock_i);
        for (int i = 0; i < 40 && busy_i !== 2'h0; i++) @(posedge clock_i);
    endtask
    task automatic t_ident;
        logic [95:0] id;
        id = {`ID_UNIQUE, `ID_DIE, `ID_PART};
        for (int i = 0; i < 12; i++) begin
            rd(i[7:0]); chk("ident", id[8*i +: 8], d);
        end
        @(posedge clock_i); booted_i <= 1'b0;
        rd(`ADDR_SYS_STATE); chk("booting", 8'h00, d);
        rd(`ADDR_UID0); chk("hidden", 8'h00, d);
        @(posedge clock_i); booted_i <= 1'b1;
    endtask
    task automatic t_measure;
        wr(`ADDR_RUN_MODE, 8'h03); chk("mode", 8'h03, {6'h00, run_mode_o});
        wr(`ADDR_TRIGGER, 8'h03); chk("start", 8'h03, {6'h00, start_o});
        rd(`ADDR_ACTIVITY); chk("busy", 8'h03, d);
        wr(`ADDR_TRIGGER, 8'h00); chk("nostart", 8'h00, {6'h00, start_o});
        wr(`ADDR_HALT, 8'h00);
        chk("nohalt", 8'h00, {6'h00, halt_o});
        wr(`ADDR_HALT, 8'h03); chk("halt", 8'h03, {6'h00, halt_o});
        idle; rd(`ADDR_ACTIVITY); chk("idle", 8'h00, d);
    endtask
    task automatic t_readout;
        temp_i <= 24'h0B_49FD;
        rd(`ADDR_TEMP0); chk("t0", 8'hFD, d);
        temp_i <= 24'h00_0000;
        rd(8'h31); chk("t1", 8'h49, d);
        rd(`ADDR_TEMP2); chk("t2", 8'h0B, d);
        humid_i <= 24'hF5_2E6C;
        rd(`ADDR_HUMID0);
        chk("h0", 8'h6C, d);
        humid_i <= 24'h00_0000;
        rd(8'h34);
        chk("h1", 8'h2E, d);
        rd(`ADDR_HUMID2);
        chk("h2", 8'hF5, d);
    endtask
    task automatic t_gap;
        wr(8'h0C, 8'hFF);
        rd(8'h0C); chk("gap", 8'h00, d);
        rd(8'h25); chk("gap", 8'h00, d);
    endtask
    task automatic t_reset;
        wr(`ADDR_RUN_MODE, 8'h02); wr(`ADDR_SYS_CONTROL, 8'h80);
        repeat (10) @(posedge clock_i);
        rd(`ADDR_RUN_MODE); chk("mode", 8'h00, d);
        rd(`ADDR_SYS_CONTROL); chk("control", 8'h01, d);
        rd(`ADDR_SYS_STATE); chk("state", 8'h01, d);
    endtask
    task automatic t_power(input logic lp);
        wr(`ADDR_SYS_CONTROL, {7'h00, lp}); wr(`ADDR_TRIGGER, 8'h01); idle;
        rd(`ADDR_SYS_STATE); chk("awake", {7'h00, ~lp}, d);
    endtask
    task automatic test_done;
        $display("n_errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // cycle ceiling against a hang
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            test_done;
        end
    end
    initial begin
        repeat (10) @(posedge clock_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        t_ident; t_measure; t_readout; t_gap; t_reset; t_power(1'b0); t_power(1'b1);
        test_done;
    end
endmodule
`default_nettype wire
